// >>> serial_flags_pkg.sv
/*
 * Package for the serial channel status and flag-clear register bank.
 * Holds register offsets, bit positions, reset values and event carriers.
 * Assumes a plain address/strobe register port with 20-bit byte addresses.
 */
package serial_flags_pkg;

	localparam int ADDR_W = 20; // Register port address width
	localparam int DATA_W = 8; // Register data width
	localparam int NUM_CH = 2; // Channels in the unit

	localparam logic [19:0] OFS_CH0_STATUS = 20'hF0100; // channel0_status
	localparam logic [19:0] OFS_CH1_STATUS = 20'hF0102; // channel1_status
	localparam logic [19:0] OFS_CH0_CLEAR = 20'hF0108; // channel0_flag_clear
	localparam logic [19:0] OFS_CH1_CLEAR = 20'hF010A; // channel1_flag_clear

	// Status register bit positions
	localparam int BIT_TRANSFER_ACTIVE = 6;
	localparam int BIT_BUFFER_VALID = 5;
	localparam int BIT_FRAMING_ERR = 2;
	localparam int BIT_PARITY_ERR = 1;
	localparam int BIT_OVERRUN_ERR = 0;

	// Flag-clear register bit positions
	localparam int BIT_FRAMING_CLR = 2;
	localparam int BIT_PARITY_CLR = 1;
	localparam int BIT_OVERRUN_CLR = 0;

	localparam logic [7:0] STATUS_RESET = 8'h00; // Status after reset
	localparam logic [7:0] CLEAR_READ_VALUE = 8'h00; // Flag-clear always reads this
	localparam logic [7:0] UNMAPPED_READ = 8'h00; // Answer to unmapped reads

	// Per-channel events from the serial datapath
	typedef struct packed {
		logic comm_start; // Communication starts
		logic comm_end; // Communication ends
		logic stop_trig; // Channel stop trigger written
		logic start_trig; // Channel start trigger written
		logic tx_enable; // Transmit enable level
		logic rx_enable; // Receive enable level
		logic buf_sw_write; // Software wrote the data buffer
		logic buf_sw_read_done; // Software finished reading the data buffer
		logic buf_rx_store; // Receiver stored data into the data buffer
		logic buf_tx_move; // Transmit data moved into the shift register
		logic framing_err; // Missing stop bit at end of reception
		logic parity_err; // Parity mismatch at end of reception
	} chan_events_t;

	// Per-channel status flags
	typedef struct packed {
		logic transfer_active;
		logic buffer_valid;
		logic framing_err;
		logic parity_err;
		logic overrun_err;
	} chan_flags_t;

endpackage

// >>> serial_channel_status_flags.sv
/*
 * Status and error-flag register bank for the two channels of a serial unit.
 * Assumes channel events arrive as one-cycle pulses (enables as levels) from
 * logic on i_core_clk, so no synchronisers are used on them.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Writing 1 to bit 2 clears framing error
// - Writing 1 to bit 1 clears parity error
// - Writing 1 to bit 0 clears overrun error
// - Framing clear bit exists on channel 1 only
// - Flag-clear register always reads zero
// - Status is read-only, 8-bit, resets to zero
// - Transfer flag set when communication starts
// - Transfer flag cleared by stop, start, end
// - Buffer flag cleared when transmit data moves
// - Buffer flag cleared on read, stop, start
// - Buffer flag set by transmit write
// - Buffer flag set by receive store
// - Buffer flag set by reception error
// - Buffer write while valid sets overrun
// - Framing flag shows asynchronous framing error
// - Framing flag on channel 1 only, else zero
// - Clear triggers are self-clearing one-shot pulses
// - Missing stop bit sets framing flag
// - Parity mismatch sets parity flag
module serial_channel_status_flags #(
	parameter int NUM_CH = serial_flags_pkg::NUM_CH // Channel count
) (
	input wire logic i_core_clk, // 250 MHz core clock
	input wire logic i_reset, // Asynchronous reset, active high
	input wire logic [19:0] i_addr, // Register byte address
	input wire logic [7:0] i_wdata, // Register write data
	input wire logic i_wr, // Write strobe, one cycle
	input wire logic i_rd, // Read strobe, one cycle
	input wire serial_flags_pkg::chan_events_t [1:0] i_events, // Datapath events
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	output serial_flags_pkg::chan_flags_t [1:0] o_flags // Registered flags
);

	serial_flags_pkg::chan_flags_t [1:0] flags_r; // Flag state per channel
	serial_flags_pkg::chan_flags_t [1:0] flags_nxt; // Next flag state
	logic [7:0] rdata_r; // Registered read data
	logic [7:0] rdata_nxt; // Next read data
	logic [1:0] clr_sel; // Flag-clear write hits channel
	logic [1:0] status_sel; // Status read hits channel

	// Address decode for writes and reads
	always_comb begin
		clr_sel[0] = i_wr && (i_addr == serial_flags_pkg::OFS_CH0_CLEAR);
		clr_sel[1] = i_wr && (i_addr == serial_flags_pkg::OFS_CH1_CLEAR);
		status_sel[0] = i_addr == serial_flags_pkg::OFS_CH0_STATUS;
		status_sel[1] = i_addr == serial_flags_pkg::OFS_CH1_STATUS;
	end

	// Flag next-state per channel; the clear strobe is only a one-cycle
	// decode, so the trigger bits never hold any value of their own
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_ch
			logic clr_fe; // Framing clear pulse
			logic clr_pe; // Parity clear pulse
			logic clr_ov; // Overrun clear pulse
			logic fe_set; // Framing set event
			logic pe_set; // Parity set event
			logic ov_set; // Overrun set event
			logic rx_error; // Any reception error
			always_comb begin
				// Bit 2 is unimplemented on channel 0 and is ignored there
				clr_fe = (ch == 1) && clr_sel[ch]
					&& i_wdata[serial_flags_pkg::BIT_FRAMING_CLR];
				clr_pe = clr_sel[ch] && i_wdata[serial_flags_pkg::BIT_PARITY_CLR];
				clr_ov = clr_sel[ch] && i_wdata[serial_flags_pkg::BIT_OVERRUN_CLR];
				fe_set = (ch == 1) && i_events[ch].framing_err;
				pe_set = i_events[ch].parity_err;
				// Overrun: buffer write while it already holds valid data
				ov_set = flags_r[ch].buffer_valid
					&& (i_events[ch].buf_sw_write || i_events[ch].buf_rx_store);
				rx_error = fe_set || pe_set || ov_set;
				flags_nxt[ch] = flags_r[ch];

				// Transfer flag: stop or start suspends, end clears, start of comm sets
				if (i_events[ch].stop_trig || i_events[ch].start_trig
					|| i_events[ch].comm_end) begin
					flags_nxt[ch].transfer_active = 1'b0;
				end else if (i_events[ch].comm_start) begin
					flags_nxt[ch].transfer_active = 1'b1;
				end

				// Buffer flag: set sources first win over a same-cycle clear
				if ((i_events[ch].buf_sw_write && i_events[ch].tx_enable)
					|| (i_events[ch].buf_rx_store && i_events[ch].rx_enable)) begin
					flags_nxt[ch].buffer_valid = 1'b1;
				end else if (rx_error) begin
					flags_nxt[ch].buffer_valid = 1'b1;
				end else if (i_events[ch].stop_trig || i_events[ch].start_trig) begin
					flags_nxt[ch].buffer_valid = 1'b0;
				end else if (i_events[ch].buf_sw_read_done) begin
					flags_nxt[ch].buffer_valid = 1'b0;
				end else if (i_events[ch].buf_tx_move) begin
					flags_nxt[ch].buffer_valid = 1'b0;
				end

				// Error flags: a set in the clear cycle keeps the error
				if (fe_set) begin
					flags_nxt[ch].framing_err = 1'b1;
				end else if (clr_fe) begin
					flags_nxt[ch].framing_err = 1'b0;
				end
				if (pe_set) begin
					flags_nxt[ch].parity_err = 1'b1;
				end else if (clr_pe) begin
					flags_nxt[ch].parity_err = 1'b0;
				end
				if (ov_set) begin
					flags_nxt[ch].overrun_err = 1'b1;
				end else if (clr_ov) begin
					flags_nxt[ch].overrun_err = 1'b0;
				end
				// Channel 0 has no framing flag at all
				if (ch == 0) begin
					flags_nxt[ch].framing_err = 1'b0;
				end
			end
		end
	endgenerate

	// Read mux; status is read-only, writes to it are ignored
	always_comb begin
		rdata_nxt = rdata_r;
		if (i_rd) begin
			rdata_nxt = serial_flags_pkg::UNMAPPED_READ;
			for (int c = 0; c < 2; c++) begin
				if (status_sel[c]) begin
					rdata_nxt = 8'h00;
					rdata_nxt[serial_flags_pkg::BIT_TRANSFER_ACTIVE] = flags_r[c].transfer_active;
					rdata_nxt[serial_flags_pkg::BIT_BUFFER_VALID] = flags_r[c].buffer_valid;
					rdata_nxt[serial_flags_pkg::BIT_FRAMING_ERR] = flags_r[c].framing_err;
					rdata_nxt[serial_flags_pkg::BIT_PARITY_ERR] = flags_r[c].parity_err;
					rdata_nxt[serial_flags_pkg::BIT_OVERRUN_ERR] = flags_r[c].overrun_err;
				end
			end
			// Flag-clear registers hold nothing readable
			if (i_addr == serial_flags_pkg::OFS_CH0_CLEAR
				|| i_addr == serial_flags_pkg::OFS_CH1_CLEAR) begin
				rdata_nxt = serial_flags_pkg::CLEAR_READ_VALUE;
			end
		end else begin
			// Data stand for only the cycle after the read strobe
			rdata_nxt = 8'h00;
		end
	end

	// State registers
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			flags_r <= '0;
			rdata_r <= serial_flags_pkg::STATUS_RESET;
		end else begin
			flags_r <= flags_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_flags = flags_r;

endmodule

`default_nettype wire

// >>> serial_flags_monitor.sv
/* Checker for the serial status flag bank, bound to its top module.
   Assumes events are single-cycle pulses on i_core_clk. */
`timescale 1ns/1ns
`default_nettype none
module serial_flags_monitor (
	input wire logic i_core_clk, // Core clock
	input wire logic i_reset, // Async reset
	input wire logic [19:0] i_addr, // Address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire serial_flags_pkg::chan_events_t [1:0] i_events, // Events
	input wire logic [7:0] o_rdata, // Read data
	input wire serial_flags_pkg::chan_flags_t [1:0] o_flags // Flags
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	wire serial_flags_pkg::chan_events_t e0 = i_events[0]; // Channel 0 events
	wire serial_flags_pkg::chan_events_t e1 = i_events[1]; // Channel 1 events
	wire serial_flags_pkg::chan_flags_t f1 = o_flags[1]; // Channel 1 flags
	// Byte layout software sees for channel 1
	wire logic [7:0] st1 = {1'b0, f1[4:3], 2'b00, f1[2:0]};
	wire logic wr0 = i_wr && i_addr == serial_flags_pkg::OFS_CH0_CLEAR; // Clear write ch0
	wire logic wr1 = i_wr && i_addr == serial_flags_pkg::OFS_CH1_CLEAR; // Clear write ch1
	wire logic rdc = i_rd && (i_addr == serial_flags_pkg::OFS_CH0_CLEAR
		|| i_addr == serial_flags_pkg::OFS_CH1_CLEAR); // Clear register read
	a_status_readback: assert property (i_rd && i_addr == serial_flags_pkg::OFS_CH1_STATUS
		|=> o_rdata == $past(st1)) else $error("status readback wrong");
	a_clear_reads_zero: assert property (rdc |=> o_rdata == 8'h00)
		else $error("clear register read not zero");
	a_overrun_clear: assert property (wr0 && i_wdata[0] && !(o_flags[0].buffer_valid
		&& (e0.buf_sw_write || e0.buf_rx_store)) |=> !o_flags[0].overrun_err)
		else $error("overrun not cleared");
	a_parity_clear: assert property (wr1 && i_wdata[1] && !e1.parity_err
		|=> !o_flags[1].parity_err) else $error("parity not cleared");
	a_framing_clear: assert property (wr1 && i_wdata[2] && !e1.framing_err
		|=> !o_flags[1].framing_err) else $error("framing not cleared");
	a_framing_set: assert property (e1.framing_err
		|=> f1.framing_err && f1.buffer_valid) else $error("framing event lost");
	a_overrun_set: assert property (o_flags[0].buffer_valid && e0.buf_sw_write
		|=> o_flags[0].overrun_err) else $error("overrun not raised");
	a_transfer_stop: assert property (e0.stop_trig || e0.start_trig || e0.comm_end
		|=> !o_flags[0].transfer_active) else $error("transfer flag stuck");
	c_framing_cleared: cover property (wr1 && i_wdata[2] && f1.framing_err);
	c_overrun_seen: cover property (o_flags[0].overrun_err);
	c_transfer_seen: cover property (o_flags[0].transfer_active);
endmodule
bind serial_channel_status_flags serial_flags_monitor u_mon (.i_core_clk(i_core_clk),
	.i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.i_events(i_events), .o_rdata(o_rdata), .o_flags(o_flags));
`default_nettype wire

// >>> tb_serial_channel_status_flags.sv
/* Testbench for the serial status flag bank.
   Drives the register port and channel events itself; no far-side model. */
`timescale 1ns/1ns
`default_nettype none
module tb_serial_channel_status_flags;
	logic i_core_clk = 1'b0; // 4 ns clock
	logic i_reset = 1'b1; // Held ten cycles
	logic i_wr = 1'b0; // Write strobe
	logic i_rd = 1'b0; // Read strobe
	logic [19:0] i_addr = 20'h00000; // Address
	logic [7:0] i_wdata = 8'h00; // Write data
	serial_flags_pkg::chan_events_t [1:0] i_events = '0; // Event pulses
	logic [7:0] o_rdata; // Read data
	serial_flags_pkg::chan_flags_t [1:0] o_flags; // Flags
	int n_fail = 0; // Mismatches
	int check_count = 0; // Comparisons
	always #2 i_core_clk = ~i_core_clk;
	serial_channel_status_flags DUT (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_events(i_events), .o_rdata(o_rdata),
		.o_flags(o_flags));
	// Counts, verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Read; data stands one cycle only, so it is looked at just after that edge
	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		check_count++;
		if (o_rdata !== exp) begin
			n_fail++;
			$display("mismatch read %h expected %h seen %h", a, exp, o_rdata);
		end
	endtask
	// Status read, then the flag outputs against the same expected byte
	task automatic st(input int ch, input logic [7:0] exp);
		rd(ch ? serial_flags_pkg::OFS_CH1_STATUS : serial_flags_pkg::OFS_CH0_STATUS, exp);
		check_count++;
		if (o_flags[ch] !== {exp[6], exp[5], exp[2:0]}) begin
			n_fail++;
			$display("mismatch flags ch%0d expected %h seen %h", ch,
				{exp[6], exp[5], exp[2:0]}, o_flags[ch]);
		end
	endtask
	// One-cycle write
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic clr(input int ch, input logic [7:0] d);
		wr(ch ? serial_flags_pkg::OFS_CH1_CLEAR : serial_flags_pkg::OFS_CH0_CLEAR, d);
	endtask
	// One-cycle event pulse; enables ride along in the same word
	task automatic ev(input int ch, input logic [11:0] v);
		@(posedge i_core_clk);
		i_events[ch] <= v;
		@(posedge i_core_clk);
		i_events[ch] <= '0;
	endtask
	initial begin
		repeat (10) @(posedge i_core_clk);
		i_reset <= 1'b0;
		st(0, 8'h00);
		st(1, 8'h00);
		rd(serial_flags_pkg::OFS_CH0_CLEAR, 8'h00);
		rd(20'hF0104, 8'h00); // Unmapped address
		$display("test reset done");
		ev(1, 12'h002); // Missing stop bit on channel 1
		st(1, 8'h24);
		wr(serial_flags_pkg::OFS_CH1_STATUS, 8'hFF); // Status is read-only
		clr(1, 8'h00);
		st(1, 8'h24);
		clr(1, 8'h04);
		st(1, 8'h20);
		rd(serial_flags_pkg::OFS_CH1_CLEAR, 8'h00);
		ev(0, 12'h002);
		st(0, 8'h00);
		ev(0, 12'h001); // Parity mismatch on channel 0
		st(0, 8'h22);
		clr(0, 8'h02);
		st(0, 8'h20);
		ev(0, 12'h0A0); // Buffer written while already valid
		st(0, 8'h21);
		clr(0, 8'h01);
		ev(0, 12'h010);
		st(0, 8'h00);
		$display("test errors done");
		ev(0, 12'h0A0);
		st(0, 8'h20);
		ev(0, 12'h004);
		st(0, 8'h00);
		ev(0, 12'h048);
		st(0, 8'h20);
		ev(0, 12'h200);
		st(0, 8'h00);
		ev(0, 12'h800);
		st(0, 8'h40);
		ev(0, 12'h400);
		st(0, 8'h00);
		ev(0, 12'h800);
		ev(0, 12'h100);
		st(0, 8'h00);
		$display("test buffer and transfer done");
		// Parity event and its clear land on the same edge
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= serial_flags_pkg::OFS_CH1_CLEAR;
		i_wdata <= 8'h02;
		i_events[1] <= 12'h001;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		i_events[1] <= '0;
		st(1, 8'h22);
		clr(1, 8'h02);
		st(1, 8'h20);
		$display("test set wins done");
		report_and_stop();
	end
	// Watchdog well beyond the expected hundred or so cycles
	initial begin
		#20000;
		n_fail++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
`default_nettype wire
